// *** bench/drive_input_mode_logic_bench.sv ***
`timescale 1ns/100ps
module drive_input_mode_logic_bench;
  import drive_mode_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  contacts_s want = 9'h101;
  contacts_s cts;
  op_mode_e mode = MODE_KEYPAD;
  cmd_select_e cs = CMD_SRC_POT;
  logic len = 1'b1, trip_set = 1'b1, key_req = 1'b0, kp_run = 1'b0, kp_rst = 1'b0, key;
  logic kp_stop = 1'b0, kp_rev = 1'b0;
  logic [3:0] aout = 4'h0, dout = 4'h0, aout_o, dout_o;
  drive_cmd_s cmd;
  logic local_o, fault_o, log_o, stop_o, lexp;
  integer fails = 0, tests_run = 0, seed = 8, cyc = 0, i;
  logic [3:0] r;
  initial forever #20 sys_clk_i = ~sys_clk_i;
  operator_panel_model u_panel (.sys_clk_i(sys_clk_i), .closed_i(want), .key_req_i(key_req),
    .contacts_o(cts), .local_key_press_o(key));
  drive_input_mode_logic u_dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .contacts_i(cts),
    .op_mode_i(mode), .cmd_select_i(cs), .local_enable_setting_i(len), .ext_trip_setting_i(trip_set),
    .local_key_press_i(key), .keypad_run_i(kp_run), .keypad_stop_i(kp_stop), .keypad_reverse_i(kp_rev),
    .keypad_reset_i(kp_rst), .analog_out_i(aout), .digital_out_i(dout), .drive_cmd_o(cmd),
    .local_active_o(local_o), .ext_trip_fault_o(fault_o), .fault_log_pulse_o(log_o),
    .stop_pulse_o(stop_o), .analog_out_o(aout_o), .digital_out_o(dout_o));
  function logic [3:0] exp_src(input logic [3:0] b, input cmd_select_e c);
    if (!b[1] || !b[0]) return {1'b1, SPD_PRESET};
    if (!b[2]) return {1'b0, SPD_KEYPAD};
    if (b[3] || c == CMD_SRC_POT) return {1'b0, SPD_AIN1};
    return {1'b0, SPD_CMDSEL};
  endfunction
  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task final_report;
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      fails++;
      final_report;
    end
  end
  initial
  begin
    repeat (10) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    lexp = RESET_LOCAL;
    chk(local_o, lexp);
    for (i = 0; i < 8; i++)
    begin
      @(posedge sys_clk_i);
      want <= contacts_s'($random(seed)) | 9'h101;
      aout <= 4'($random(seed));
      dout <= 4'($random(seed));
      key_req <= 1'b1;
      @(posedge sys_clk_i);
      key_req <= 1'b0;
      tick(3);
      lexp = ~lexp;
      chk(local_o, lexp);
      chk({cmd.preset_valid, cmd.run}, 2'b00);
      chk({aout_o, dout_o}, {aout, dout});
    end
    $display("keypad test done");
    @(posedge sys_clk_i);
    mode <= MODE_SPEED15_2W;
    for (i = 0; i < 16; i++)
    begin
      r = 4'(i);
      @(posedge sys_clk_i);
      want <= {3'b100, r[0], r[1], r[2], r[3], 2'b01};
      tick(3);
      if (i == 15) chk(cmd.fault_reset, 1'b1);
      else chk({cmd.preset_valid, cmd.preset_idx}, {1'b1, r});
    end
    $display("speed code test done");
    @(posedge sys_clk_i);
    mode <= MODE_FANPUMP_2W;
    for (i = 0; i < 24; i++)
    begin
      r = (i < 4) ? {2'b11, 2'(i)} : 4'($random(seed));
      @(posedge sys_clk_i);
      cs <= cmd_select_e'($random(seed));
      want <= {3'b110, r[3], 1'b1, r[2], r[1], r[0], 1'b1};
      tick(3);
      chk({cmd.preset_valid, cmd.speed_src}, exp_src(r, cs));
      if (!r[1] || !r[0]) chk(cmd.preset_idx, r[1] ? PRESET_TWO_IDX : PRESET_ONE_IDX);
    end
    for (i = 0; i < 3; i++)
    begin
      r = (i == 0) ? 4'h2 : (i == 1) ? 4'h0 : 4'h1;
      @(posedge sys_clk_i);
      want <= {1'b1, r[1:0], 6'h3f};
      tick(3);
      chk({cmd.run, cmd.reverse}, (i == 2) ? 2'b11 : {r[1], 1'b0});
    end
    $display("fan pump test done");
    @(posedge sys_clk_i);
    want <= 9'h0bf;
    tick(3);
    chk({cmd.output_enable, cmd.run}, 2'b00);
    @(posedge sys_clk_i);
    len <= 1'b0;
    tick(3);
    chk(cmd.output_enable, 1'b1);
    @(posedge sys_clk_i);
    len <= 1'b1;
    want <= 9'h1be;
    tick(3);
    chk({stop_o, log_o, fault_o, cmd.run, cmd.output_enable}, 5'b11100);
    tick(1);
    chk({stop_o, log_o, fault_o}, 3'b001);
    @(posedge sys_clk_i);
    want <= 9'h1af;
    tick(3);
    @(posedge sys_clk_i);
    kp_rst <= 1'b1;
    @(posedge sys_clk_i);
    kp_rst <= 1'b0;
    tick(2);
    chk({fault_o, cmd.run}, 2'b00);
    @(posedge sys_clk_i);
    kp_run <= 1'b1;
    @(posedge sys_clk_i);
    kp_run <= 1'b0;
    tick(2);
    chk({cmd.run, cmd.reverse}, 2'b10);
    @(posedge sys_clk_i);
    kp_stop <= 1'b1;
    @(posedge sys_clk_i);
    kp_stop <= 1'b0;
    tick(2);
    chk({cmd.run, cmd.reverse}, 2'b00);
    @(posedge sys_clk_i);
    kp_run <= 1'b1;
    kp_rev <= 1'b1;
    @(posedge sys_clk_i);
    kp_run <= 1'b0;
    kp_rev <= 1'b0;
    tick(2);
    chk({cmd.run, cmd.reverse}, 2'b11);
    $display("enable and trip test done");
    final_report;
  end
endmodule

// *** bench/drive_mode_checker.sv ***
`timescale 1ns/100ps
module drive_mode_checker
  import drive_mode_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire contacts_s contacts_i,
  input wire op_mode_e op_mode_i,
  input wire logic local_enable_setting_i,
  input wire logic ext_trip_setting_i,
  input wire logic local_key_press_i,
  input wire logic [3:0] analog_out_i,
  input wire drive_cmd_s drive_cmd_o,
  input wire logic local_active_o,
  input wire logic ext_trip_fault_o,
  input wire logic fault_log_pulse_o,
  input wire logic stop_pulse_o,
  input wire logic [3:0] analog_out_o
);
  logic [2:0] up_q;
  logic [2:0] up_d;
  logic ok;
  logic [3:0] code;
  logic [1:0] fr;
  // past values reach back three edges, so stay quiet until that history is clean
  always_comb up_d = (up_q == 3'h7) ? up_q : up_q + 3'h1;
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
    if (!rst_b_i) up_q <= 3'h0;
    else up_q <= up_d;
  assign ok = (up_q == 3'h7);
  assign code = {contacts_i.preset_one_contact, contacts_i.speed_source_contact,
                 contacts_i.run_source_contact, contacts_i.analog_select_contact};
  assign fr = {contacts_i.forward_run_contact, contacts_i.reverse_run_contact};
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence trip_opens;
    ok && ext_trip_setting_i && !ext_trip_fault_o && $fell(contacts_i.external_trip_contact);
  endsequence
  sequence trip_answer;
    ##3 (stop_pulse_o && fault_log_pulse_o && ext_trip_fault_o && !drive_cmd_o.run) ##1 !stop_pulse_o;
  endsequence
  a_trip_response: assert property (trip_opens |-> trip_answer) else $error("trip answer wrong");
  a_trip_forces_stop: assert property (ext_trip_fault_o |-> !drive_cmd_o.run && !drive_cmd_o.output_enable)
    else $error("run while tripped");
  a_enable_gate: assert property (ok && drive_cmd_o.output_enable && $past(local_enable_setting_i)
    |-> $past(contacts_i.enable_contact, 3)) else $error("enabled with contact open");
  a_outputs_pass: assert property (ok |-> analog_out_o == $past(analog_out_i)) else $error("analog out lost");
  a_local_toggle: assert property (ok && $past(op_mode_i) == MODE_KEYPAD && $past(local_key_press_i)
    |-> local_active_o != $past(local_active_o)) else $error("local not toggled");
  a_keypad_ignores: assert property (ok && $past(op_mode_i) == MODE_KEYPAD |-> !drive_cmd_o.preset_valid)
    else $error("keypad mode used contacts");
  a_speed15_code: assert property (ok && $past(op_mode_i) == MODE_SPEED15_2W && drive_cmd_o.preset_valid
    |-> drive_cmd_o.preset_idx == $past(code, 3) && $past(code, 3) != SPEED15_RESET_CODE)
    else $error("preset code wrong");
  a_fan_preset_one: assert property (ok && $past(op_mode_i) == MODE_FANPUMP_2W && drive_cmd_o.output_enable
    && !$past(contacts_i.preset_one_contact, 3) |-> drive_cmd_o.preset_valid
    && drive_cmd_o.preset_idx == PRESET_ONE_IDX) else $error("preset one lost");
  a_fan_stop: assert property (ok && $past(op_mode_i) == MODE_FANPUMP_2W
    && $past(contacts_i.run_source_contact, 3) && $past(fr, 3) == 2'b00 |-> !drive_cmd_o.run)
    else $error("run with both open");
endmodule
bind drive_input_mode_logic drive_mode_checker u_chk (.*);

// *** bench/operator_panel_model.sv ***
`timescale 1ns/100ps
module operator_panel_model
  import drive_mode_pkg::*;
(
  input wire logic sys_clk_i,
  input wire contacts_s closed_i,
  input wire logic key_req_i,
  output contacts_s contacts_o,
  output logic local_key_press_o
);
  logic key_q;
  // a held key still gives one press, as the model passes only the rising edge of key_req_i
  always_ff @(posedge sys_clk_i) key_q <= key_req_i;
  assign contacts_o = closed_i;
  assign local_key_press_o = key_req_i && !key_q;
endmodule

// *** src/drive_input_mode_logic.sv ***
`timescale 1ns/100ps
module drive_input_mode_logic
  import drive_mode_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire contacts_s contacts_i,
  input wire op_mode_e op_mode_i,
  input wire cmd_select_e cmd_select_i,
  input wire logic local_enable_setting_i,
  input wire logic ext_trip_setting_i,
  input wire logic local_key_press_i,
  input wire logic keypad_run_i,
  input wire logic keypad_stop_i,
  input wire logic keypad_reverse_i,
  input wire logic keypad_reset_i,
  input wire logic [3:0] analog_out_i,
  input wire logic [3:0] digital_out_i,
  output drive_cmd_s drive_cmd_o,
  output logic local_active_o,
  output logic ext_trip_fault_o,
  output logic fault_log_pulse_o,
  output logic stop_pulse_o,
  output logic [3:0] analog_out_o,
  output logic [3:0] digital_out_o
);

  // two-flop synchroniser for the isolated contacts
  contacts_s sync1_q, sync1_d;
  contacts_s sync2_q, sync2_d;

  // control state
  logic local_q, local_d;
  logic trip_q, trip_d;
  logic log_q, log_d;
  logic stop_q, stop_d;
  run_state_e run_q, run_d;
  logic term_run_q, term_run_d;
  logic term_spd_q, term_spd_d;
  logic held_q, held_d;
  logic [3:0] aout_q, aout_d;
  logic [3:0] dout_q, dout_d;
  drive_cmd_s cmd_q, cmd_d;

  function automatic speed_src_e terminal_source(input cmd_select_e sel, input logic ain_sel);
    if (sel == CMD_SRC_POT || ain_sel)
    begin
      terminal_source = SPD_AIN1;
    end
    else
    begin
      terminal_source = SPD_CMDSEL;
    end
  endfunction

  function automatic logic [3:0] analog_in_pass(input logic [3:0] v);
    analog_in_pass = v;
  endfunction

  function automatic logic speed15_reset(input logic [3:0] code);
    speed15_reset = (code == SPEED15_RESET_CODE);
  endfunction

  always_comb
  begin
    sync1_d = contacts_i;
    sync2_d = sync1_q;
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      // an open trip contact is only believed once the real pin has passed both flops
      sync1_q <= CONTACTS_RESET;
      sync2_q <= CONTACTS_RESET;
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  logic keypad_mode;
  logic enabled;
  logic trip_now;
  logic run_terminal;
  logic spd_terminal;
  logic [3:0] code15;

  always_comb
  begin
    keypad_mode = (op_mode_i == MODE_KEYPAD);
    // enable contact honoured only when the setting is on; otherwise treated as closed
    enabled = !local_enable_setting_i || sync2_q.enable_contact;
    trip_now = ext_trip_setting_i && !sync2_q.external_trip_contact;
    run_terminal = !keypad_mode && sync2_q.run_source_contact;
    spd_terminal = !keypad_mode && sync2_q.speed_source_contact;
    code15 = {sync2_q.preset_one_contact, sync2_q.speed_source_contact,
              sync2_q.run_source_contact, sync2_q.analog_select_contact};
  end

  // local/remote only toggles in keypad mode; the display follows local_q
  always_comb
  begin
    local_d = local_q;
    if (keypad_mode && local_key_press_i)
    begin
      local_d = !local_q;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      local_q <= RESET_LOCAL;
    end
    else
    begin
      local_q <= local_d;
    end
  end

  // outputs keep running in every mode, keypad-only included
  always_comb
  begin
    aout_d = analog_in_pass(analog_out_i);
    dout_d = digital_out_i;
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      aout_q <= '0;
      dout_q <= '0;
    end
    else
    begin
      aout_q <= aout_d;
      dout_q <= dout_d;
    end
  end

  // run direction is held from the cycle after a keypad-to-terminal switchover (fan/pump 2W only, until both source contacts open); speed is not held
  always_comb
  begin
    term_run_d = run_terminal;
    term_spd_d = spd_terminal;
    held_d = held_q;
    if ((run_terminal && !term_run_q) || (spd_terminal && !term_spd_q))
    begin
      held_d = 1'b1;
    end
    else if (!run_terminal && !spd_terminal)
    begin
      held_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      term_run_q <= 1'b0;
      term_spd_q <= 1'b0;
      held_q <= 1'b0;
    end
    else
    begin
      term_run_q <= term_run_d;
      term_spd_q <= term_spd_d;
      held_q <= held_d;
    end
  end

  always_comb
  begin
    trip_d = trip_q;
    log_d = 1'b0;
    stop_d = 1'b0;
    run_d = run_q;
    cmd_d = cmd_q;
    cmd_d.fault_reset = 1'b0;
    cmd_d.preset_valid = 1'b0;
    cmd_d.preset_idx = '0;

    // run decision by mode
    if (op_mode_i == MODE_FANPUMP_2W && run_terminal)
    begin
      if (sync2_q.forward_run_contact)
      begin
        run_d = RUN_FWD;
      end
      else if (sync2_q.reverse_run_contact)
      begin
        run_d = RUN_REV;
      end
      else
      begin
        run_d = RUN_IDLE;
      end
      if (held_q && run_q != RUN_IDLE && run_d != RUN_IDLE)
      begin
        run_d = run_q;
      end
    end
    else if (op_mode_i == MODE_SPEED15_2W)
    begin
      if (sync2_q.forward_run_contact)
      begin
        run_d = RUN_FWD;
      end
      else if (sync2_q.reverse_run_contact)
      begin
        run_d = RUN_REV;
      end
      else
      begin
        run_d = RUN_IDLE;
      end
    end
    else
    begin
      if (keypad_stop_i)
      begin
        run_d = RUN_IDLE;
      end
      else if (keypad_run_i)
      begin
        run_d = keypad_reverse_i ? RUN_REV : RUN_FWD;
      end
    end

    // speed source
    if (op_mode_i == MODE_SPEED15_2W)
    begin
      cmd_d.speed_src = SPD_PRESET;
      if (speed15_reset(code15))
      begin
        cmd_d.fault_reset = 1'b1;
      end
      else
      begin
        cmd_d.preset_valid = 1'b1;
        cmd_d.preset_idx = code15;
      end
    end
    else if (op_mode_i == MODE_FANPUMP_2W && !sync2_q.preset_one_contact)
    begin
      cmd_d.speed_src = SPD_PRESET;
      cmd_d.preset_valid = 1'b1;
      cmd_d.preset_idx = PRESET_ONE_IDX;
    end
    else if (op_mode_i == MODE_FANPUMP_2W && !sync2_q.preset_two_contact)
    begin
      cmd_d.speed_src = SPD_PRESET;
      cmd_d.preset_valid = 1'b1;
      cmd_d.preset_idx = PRESET_TWO_IDX;
    end
    else if (spd_terminal)
    begin
      cmd_d.speed_src = terminal_source(cmd_select_i, sync2_q.analog_select_contact);
    end
    else
    begin
      cmd_d.speed_src = SPD_KEYPAD;
    end

    // reset source
    if (run_terminal ? (op_mode_i == MODE_SPEED15_2W && speed15_reset(code15)) : keypad_reset_i)
    begin
      cmd_d.fault_reset = 1'b1;
    end
    if (!run_terminal && keypad_reset_i)
    begin
      cmd_d.fault_reset = 1'b1;
    end

    // trip latches until a fault reset with the contact closed again
    if (trip_now && !trip_q)
    begin
      trip_d = 1'b1;
      log_d = 1'b1;
      stop_d = 1'b1;
    end
    else if (trip_q && cmd_d.fault_reset && !trip_now)
    begin
      trip_d = 1'b0;
    end

    if (trip_d || !enabled)
    begin
      run_d = RUN_IDLE;
      cmd_d.preset_valid = 1'b0;
      cmd_d.speed_src = SPD_KEYPAD;
    end
    cmd_d.run = (run_d != RUN_IDLE);
    cmd_d.reverse = (run_d == RUN_REV);
    cmd_d.output_enable = enabled && !trip_d;
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      trip_q <= RESET_TRIP;
      log_q <= 1'b0;
      stop_q <= 1'b0;
      run_q <= RUN_IDLE;
      cmd_q <= '0;
    end
    else
    begin
      trip_q <= trip_d;
      log_q <= log_d;
      stop_q <= stop_d;
      run_q <= run_d;
      cmd_q <= cmd_d;
    end
  end

  always_comb
  begin
    drive_cmd_o = cmd_q;
    local_active_o = local_q;
    ext_trip_fault_o = trip_q;
    fault_log_pulse_o = log_q;
    stop_pulse_o = stop_q;
    analog_out_o = aout_q;
    digital_out_o = dout_q;
  end

endmodule

// *** src/drive_mode_pkg.sv ***
package drive_mode_pkg;

  // operating mode codes as held in the input parameter group
  typedef enum logic [3:0] {
    MODE_KEYPAD     = 4'h0,
    MODE_STD_3WIRE  = 4'h1,
    MODE_SPEED15_2W = 4'h2,
    MODE_FANPUMP_2W = 4'h3,
    MODE_FANPUMP_3W = 4'h4,
    MODE_SERIAL     = 4'h5,
    MODE_PROCESS    = 4'h6,
    MODE_ANALOG3_2W = 4'h7,
    MODE_ANALOG3_3W = 4'h8,
    MODE_EPOT_2W    = 4'h9,
    MODE_EPOT_3W    = 4'ha
  } op_mode_e;

  typedef enum logic [1:0] {
    CMD_SRC_POT    = 2'h0,
    CMD_SRC_AIN1   = 2'h1,
    CMD_SRC_AIN2   = 2'h2,
    CMD_SRC_OTHER  = 2'h3
  } cmd_select_e;

  typedef enum logic [2:0] {
    SPD_KEYPAD = 3'h0,
    SPD_AIN1   = 3'h1,
    SPD_CMDSEL = 3'h2,
    SPD_PRESET = 3'h3
  } speed_src_e;

  typedef enum logic [1:0] {
    RUN_IDLE = 2'b00,
    RUN_FWD  = 2'b01,
    RUN_REV  = 2'b10
  } run_state_e;

  // isolated terminal-strip contacts, 1 = closed to input_common
  typedef struct packed {
    logic enable_contact;
    logic forward_run_contact;
    logic reverse_run_contact;
    logic analog_select_contact;
    logic run_source_contact;
    logic speed_source_contact;
    logic preset_one_contact;
    logic preset_two_contact;
    logic external_trip_contact;
  } contacts_s;

  typedef struct packed {
    logic run;
    logic reverse;
    logic output_enable;
    logic fault_reset;
    speed_src_e speed_src;
    logic [3:0] preset_idx;
    logic preset_valid;
  } drive_cmd_s;

  localparam int CONTACT_W = 9;
  localparam int SYNC_STAGES = 2;
  localparam logic [3:0] SPEED15_RESET_CODE = 4'hf;
  localparam logic [3:0] PRESET_ONE_IDX = 4'h0;
  localparam logic [3:0] PRESET_TWO_IDX = 4'h1;
  localparam logic RESET_LOCAL = 1'b1;
  localparam logic RESET_TRIP = 1'b0;
  localparam logic [1:0] RESET_RUN = 2'b00;
  // synchroniser value after reset: trip contact reads closed so reset alone cannot latch a trip
  localparam contacts_s CONTACTS_RESET = 9'h001;

endpackage
